/* File: pkg/tsr_defines.svh */
// constants for the tapped 64-stage shift register
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// ********************************************************************
// register geometry
// ********************************************************************
`define TSR_STAGES      64
`define TSR_TAPS        4
// zero-based stage index of each output tap (stages 16, 32, 48, 64)
`define TSR_TAP0_POS    15
`define TSR_TAP1_POS    31
`define TSR_TAP2_POS    47
`define TSR_TAP3_POS    63
// zero-based stage index loaded from taps 0..2 (stages 17, 33, 49)
`define TSR_LOAD0_POS   16
`define TSR_LOAD1_POS   32
`define TSR_LOAD2_POS   48

// ********************************************************************
// reset values and buffer sizing
// ********************************************************************
`define TSR_STAGE_RST   64'h0000_0000_0000_0000
`define TSR_FIFO_DEPTH  2

`endif

/* File: pkg/tsr_pkg.sv */
// types shared by the tapped shift register design
package tsr_pkg;

   // full register contents, bit 0 is stage 1
   typedef logic [63:0] tsr_stages_t;

   // one bit per tap pin, bit 0 is the 16th-stage tap
   typedef logic [3:0]  tsr_taps_t;

   // occupancy of the output buffer
   typedef logic [1:0]  tsr_count_t;

endpackage

/* File: hdl/tsr_top.sv */
// tapped 64-stage shift register with synchronised pins and output buffer
`timescale 1ns/1ps
`include "tsr_defines.svh"

module tsr_top #(
   parameter int FIFO_DEPTH = `TSR_FIFO_DEPTH
) (
   // system clock and reset
   input  wire logic                  CLK_IN,
   input  wire logic                  RST_B_IN,
   // serial pins from the partner
   input  wire logic                  SHIFT_CLK_IN,
   input  wire logic                  WRITE_EN_IN,
   input  wire logic                  SERIAL_DATA_IN,
   // two-way tap pins
   input  wire tsr_pkg::tsr_taps_t    TAP_IN,
   output logic      [3:0]            TAP_OUT,
   output logic      [3:0]            TAP_OE_OUT,
   // stream of bits leaving stage 64
   output logic                       SHIFT_READY_OUT,
   output logic                       OUT_VALID_OUT,
   output logic                       OUT_DATA_OUT,
   input  wire logic                  OUT_READY_IN,
   output logic                       OVERFLOW_OUT
);

   // ********************************************************************
   // reset release
   // ********************************************************************
   logic                  rst_meta_r;
   logic                  rst_b_r;

   // async assert, release through two flops
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_meta_r <= 1'b0;
         rst_b_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_b_r    <= rst_meta_r;
      end
   end

   // ********************************************************************
   // pin synchronisers
   // ********************************************************************
   logic                  sclk_meta_r;
   logic                  sclk_s_r;
   logic                  sclk_d_r;
   logic                  we_meta_r;
   logic                  we_s_r;
   logic                  din_meta_r;
   logic                  din_s_r;
   tsr_pkg::tsr_taps_t    tap_meta_r;
   tsr_pkg::tsr_taps_t    tap_s_r;

   // all pins share one latency, so data and enable stay aligned to the clock edge
   always_ff @(posedge CLK_IN or negedge rst_b_r) begin
      if (!rst_b_r) begin
         sclk_meta_r <= 1'b0;
         sclk_s_r    <= 1'b0;
         sclk_d_r    <= 1'b0;
         we_meta_r   <= 1'b0;
         we_s_r      <= 1'b0;
         din_meta_r  <= 1'b0;
         din_s_r     <= 1'b0;
         tap_meta_r  <= 4'h0;
         tap_s_r     <= 4'h0;
      end else begin
         sclk_meta_r <= SHIFT_CLK_IN;
         sclk_s_r    <= sclk_meta_r;
         sclk_d_r    <= sclk_s_r;      // edge detector history, never the meta flop
         we_meta_r   <= WRITE_EN_IN;
         we_s_r      <= we_meta_r;
         din_meta_r  <= SERIAL_DATA_IN;
         din_s_r     <= din_meta_r;
         tap_meta_r  <= TAP_IN;
         tap_s_r     <= tap_meta_r;
      end
   end

   // ********************************************************************
   // shift register
   // ********************************************************************
   logic                  shift_evt;
   tsr_pkg::tsr_stages_t  stage_r;
   tsr_pkg::tsr_stages_t  stage_nxt;

   // rising edge of the pin clock is the shifting transition; falling is ignored
   assign shift_evt = sclk_s_r & ~sclk_d_r;

   // next contents for one shift step
   function automatic tsr_pkg::tsr_stages_t shift_step(
      input tsr_pkg::tsr_stages_t cur,
      input logic                 din,
      input logic                 we,
      input tsr_pkg::tsr_taps_t   taps
   );
      tsr_pkg::tsr_stages_t nxt;
      nxt = {cur[`TSR_STAGES-2:0], din};
      if (we) begin
         nxt[`TSR_LOAD0_POS] = taps[0];
         nxt[`TSR_LOAD1_POS] = taps[1];
         nxt[`TSR_LOAD2_POS] = taps[2];
      end
      return nxt;
   endfunction

   assign stage_nxt = shift_step(stage_r, din_s_r, we_s_r, tap_s_r);

   // contents only move on a shifting edge
   always_ff @(posedge CLK_IN or negedge rst_b_r) begin
      if (!rst_b_r) begin
         stage_r <= `TSR_STAGE_RST;
      end else if (shift_evt) begin
         stage_r <= stage_nxt;
      end
   end

   // ********************************************************************
   // tap pins
   // ********************************************************************
   // values come straight from the stage flops; enables from the synced write enable
   assign TAP_OUT    = {stage_r[`TSR_TAP3_POS], stage_r[`TSR_TAP2_POS],
                        stage_r[`TSR_TAP1_POS], stage_r[`TSR_TAP0_POS]};
   assign TAP_OE_OUT = {4{~we_s_r}};

   // ********************************************************************
   // output buffer of bits leaving stage 64
   // ********************************************************************
   logic                  fifo_mem [FIFO_DEPTH];
   logic                  wr_ptr_r;
   logic                  rd_ptr_r;
   tsr_pkg::tsr_count_t   count_r;
   logic                  push;
   logic                  pop;
   logic                  fifo_full;
   logic                  overflow_r;

   // the pin clock cannot be stalled, so full is reported ahead and overflow is sticky
   assign fifo_full       = (count_r == 2'(FIFO_DEPTH));
   assign SHIFT_READY_OUT = ~fifo_full | OUT_READY_IN;
   assign OUT_VALID_OUT   = (count_r != 2'h0);
   assign pop             = OUT_VALID_OUT & OUT_READY_IN;
   assign push            = shift_evt & (~fifo_full | pop);
   assign OUT_DATA_OUT    = fifo_mem[rd_ptr_r];

   // storage writes
   always_ff @(posedge CLK_IN or negedge rst_b_r) begin
      if (!rst_b_r) begin
         fifo_mem[0] <= 1'b0;
         fifo_mem[1] <= 1'b0;
      end else if (push) begin
         fifo_mem[wr_ptr_r] <= stage_r[`TSR_TAP3_POS];
      end
   end

   // pointers and occupancy
   always_ff @(posedge CLK_IN or negedge rst_b_r) begin
      if (!rst_b_r) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + 2'(push) - 2'(pop);
      end
   end

   // sticky flag: a shift arrived with no room; cleared only by reset
   always_ff @(posedge CLK_IN or negedge rst_b_r) begin
      if (!rst_b_r) begin
         overflow_r <= 1'b0;
      end else if (shift_evt && !push) begin
         overflow_r <= 1'b1;
      end
   end

   assign OVERFLOW_OUT = overflow_r;

   // ********************************************************************
   // assertions
   // ********************************************************************
   a_tap_drive_value: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      !we_s_r |-> TAP_OE_OUT == 4'hF && TAP_OUT[3] == stage_r[63]
                  && TAP_OUT[0] == stage_r[15])
      else $error("tap not driving stage contents");

   a_serial_entry: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      shift_evt |=> stage_r[0] == $past(din_s_r))
      else $error("serial bit not captured in stage one");

   a_tap_float: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      we_s_r |-> TAP_OE_OUT == 4'h0)
      else $error("tap driven while write enable high");

   a_tap_load: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      shift_evt && we_s_r |=> stage_r[16] == $past(tap_s_r[0])
         && stage_r[32] == $past(tap_s_r[1]) && stage_r[48] == $past(tap_s_r[2]))
      else $error("tap value not loaded");

   a_pin_to_tap: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      WRITE_EN_IN ##1 WRITE_EN_IN ##1 WRITE_EN_IN |-> TAP_OE_OUT == 4'h0)
      else $error("taps not floated two cycles after write enable");

   a_hold_still: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      !shift_evt |=> $stable(stage_r))
      else $error("stages changed without shifting edge");

   a_falling_ignored: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      !sclk_s_r && sclk_d_r |=> $stable(stage_r))
      else $error("stages changed on falling edge");

   a_shift_advance: assert property (@(posedge CLK_IN) disable iff (!rst_b_r)
      shift_evt && !we_s_r |=> stage_r[63:1] == $past(stage_r[62:0]))
      else $error("stages did not advance");

   c_shift_plain: cover property (@(posedge CLK_IN) disable iff (!rst_b_r)
      shift_evt && !we_s_r);
   c_shift_load: cover property (@(posedge CLK_IN) disable iff (!rst_b_r)
      shift_evt && we_s_r);
   c_buffer_full: cover property (@(posedge CLK_IN) disable iff (!rst_b_r)
      fifo_full && !OUT_READY_IN);
   c_overflow: cover property (@(posedge CLK_IN) disable iff (!rst_b_r)
      $rose(overflow_r));

endmodule // tsr_top

/* File: tb/tsr_partner.sv */
// partner model: system logic driving the shift pins and the tap wires
`timescale 1ns/1ps
module tsr_partner (
   // system clock
   input  wire logic       clk_in,
   // device side of the taps
   input  wire logic [3:0] tap_out_in,
   input  wire logic [3:0] tap_oe_in,
   // pins we drive
   output logic            shift_clk_out,
   output logic            write_en_out,
   output logic            serial_data_out,
   output logic [3:0]      tap_wire_out
);
   logic [2:0] drive_r = 3'h0;
   initial begin
      shift_clk_out = 1'b0;
      write_en_out = 1'b0;
      serial_data_out = 1'b0;
   end
   // wire level; an undriven tap shows the inverse, no pull resistors
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (tap_oe_in[i])
            tap_wire_out[i] = tap_out_in[i];
         else if (write_en_out && i < 3)
            tap_wire_out[i] = drive_r[i];
         else
            tap_wire_out[i] = ~tap_out_in[i];
      end
   end
   // one shifting pulse, pins held three cycles around each clock edge
   task automatic pulse(input logic d, input logic w, input logic [2:0] t);
      @(posedge clk_in);
      serial_data_out <= d;
      write_en_out <= w;
      drive_r <= t;
      repeat (3) @(posedge clk_in);
      shift_clk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      shift_clk_out <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
   // steady shift clock while write enable and data move
   task automatic hold(input logic w);
      @(posedge clk_in);
      write_en_out <= w;
      serial_data_out <= ~serial_data_out;
      repeat (10) @(posedge clk_in);
   endtask
endmodule // tsr_partner

/* File: tb/test_tapped_shift_register_64.sv */
// self-checking bench for the tapped shift register
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_tapped_shift_register_64;
   logic        clk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        out_ready_in = 1'b1;
   logic        shift_clk, write_en, serial_data;
   logic [3:0]  tap_wire, tap_out, tap_oe;
   logic        shift_ready, out_valid, out_data, overflow;
   logic [63:0] model_r = 64'h0;
   logic        q[$];
   logic        exp_bit;
   int          mismatches = 0;
   int          n_compared = 0;
   always #2.5 clk_in = ~clk_in;
   tsr_top u_tsr_top (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .SHIFT_CLK_IN(shift_clk),
      .WRITE_EN_IN(write_en), .SERIAL_DATA_IN(serial_data), .TAP_IN(tap_wire),
      .TAP_OUT(tap_out), .TAP_OE_OUT(tap_oe), .SHIFT_READY_OUT(shift_ready),
      .OUT_VALID_OUT(out_valid), .OUT_DATA_OUT(out_data), .OUT_READY_IN(out_ready_in),
      .OVERFLOW_OUT(overflow));
   tsr_partner u_tsr_partner (.clk_in(clk_in), .tap_out_in(tap_out), .tap_oe_in(tap_oe),
      .shift_clk_out(shift_clk), .write_en_out(write_en), .serial_data_out(serial_data),
      .tap_wire_out(tap_wire));
   // ******************************
   // shared tasks
   // ******************************
   // popped bits must leave in the order they fell off stage 64; sampled mid-cycle
   // so valid and data are settled, and popped once so a mismatch cannot skew the queue
   always @(negedge clk_in)
      if (rst_b_in && out_valid === 1'b1 && out_ready_in === 1'b1) begin
         exp_bit = (q.size() > 0) ? q.pop_front() : 1'bx;
         `CHK("stream bit", exp_bit, out_data)
      end
   task automatic wrap_up();
      if (mismatches == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic do_shift(input logic d, input logic w, input logic [2:0] t);
      logic [63:0] nxt;
      q.push_back(model_r[63]);
      nxt = {model_r[62:0], d};
      if (w) begin
         nxt[16] = t[0];
         nxt[32] = t[1];
         nxt[48] = t[2];
      end
      u_tsr_partner.pulse(d, w, t);
      model_r = nxt;
      `CHK("taps", {model_r[63], model_r[47], model_r[31], model_r[15]}, tap_out)
      `CHK("tap enables", w ? 4'h0 : 4'hF, tap_oe)
   endtask
   // ******************************
   // scenarios
   // ******************************
   task automatic t_after_reset();
      `CHK("taps", 4'h0, tap_out)
      `CHK("tap enables", 4'hF, tap_oe)
      `CHK("valid", 1'b0, out_valid)
      `CHK("overflow", 1'b0, overflow)
      `CHK("shift ready", 1'b1, shift_ready)
   endtask
   // distinct pattern so a misplaced tap or stage shows
   task automatic t_fill();
      logic [63:0] pat;
      pat = 64'hF0E1_D2C3_B4A5_9687;
      for (int i = 0; i < 64; i++)
         do_shift(pat[i], 1'b0, 3'h0);
   endtask
   // every tap code loaded, then walked out through later taps
   task automatic t_tap_load();
      for (int i = 0; i < 8; i++)
         do_shift(i[0], 1'b1, i[2:0]);
      for (int i = 0; i < 20; i++)
         do_shift(i[1], 1'b0, 3'h7);
   endtask
   // no rising shift clock, so stages must sit still
   task automatic t_hold();
      u_tsr_partner.hold(1'b1);
      `CHK("tap enables", 4'h0, tap_oe)
      `CHK("taps", {model_r[63], model_r[47], model_r[31], model_r[15]}, tap_out)
      u_tsr_partner.hold(1'b0);
      `CHK("tap enables", 4'hF, tap_oe)
      `CHK("taps", {model_r[63], model_r[47], model_r[31], model_r[15]}, tap_out)
   endtask
   // consumer stalls: two bits fit, the third is lost and flagged
   task automatic t_stall();
      out_ready_in <= 1'b0;
      do_shift(1'b1, 1'b0, 3'h0);
      do_shift(1'b0, 1'b0, 3'h0);
      `CHK("shift ready", 1'b0, shift_ready)
      do_shift(1'b1, 1'b0, 3'h0);
      `CHK("overflow", 1'b1, overflow)
      void'(q.pop_back());
      out_ready_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      `CHK("drained", 1'b0, out_valid)
   endtask
   // reset in mid-run clears stages and the sticky flag; shifting works again after
   task automatic t_reset_again();
      rst_b_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      `CHK("overflow in reset", 1'b0, overflow)
      `CHK("taps in reset", 4'h0, tap_out)
      rst_b_in <= 1'b1;
      model_r = 64'h0;
      q.delete();
      repeat (5) @(posedge clk_in);
      `CHK("overflow", 1'b0, overflow)
      `CHK("shift ready", 1'b1, shift_ready)
      for (int i = 0; i < 16; i++)
         do_shift(1'b1, 1'b0, 3'h0);
   endtask
   initial begin
      #20000;
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      t_after_reset();
      t_fill();
      t_tap_load();
      t_hold();
      t_stall();
      t_reset_again();
      wrap_up();
   end
endmodule // test_tapped_shift_register_64
